/* verilog/gsr_pkg.sv */
// Package for the global status register bank
package gsr_pkg;
    localparam logic [15:0] ADDR_INPUT_PIN_LEVELS = 16'h0219;
    localparam logic [15:0] ADDR_INTERRUPT_SUMMARY = 16'h021a;
    localparam logic [15:0] ADDR_RESERVED_STATUS = 16'h021b;
    localparam logic [15:0] ADDR_PLL0_CAL_CODE = 16'h021c;
    localparam logic [15:0] ADDR_PLL1_CAL_CODE = 16'h021d;
    localparam logic [15:0] ADDR_BOOT_FAILURE = 16'h021e;
    localparam logic [15:0] ADDR_CONFIG_LOAD = 16'h021f;
    localparam int GPI_WIDTH = 4;
    localparam int CAL_WIDTH = 6;
    localparam int CHECK_OK_BIT = 3;
    localparam int DONE_BIT = 0;
    localparam int FAIL_BIT = 0;
    localparam int IRQ_BIT = 0;
    localparam logic RESET_FLAG = 1'h0;
    localparam logic RESET_CHECK_OK = 1'h1;

    typedef struct packed {
        logic load_fail;
        logic load_done;
        logic crc_error;
    } gsr_load_evt_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } gsr_req_t;
endpackage : gsr_pkg

/* verilog/gsr_global_status.sv */
// Global status register bank: pin levels, interrupt summary, load flags
//
// Contract
// - Pin level field shows live level of each GPIO configured as input.
// - Summary bit is 1 exactly when any enabled interrupt status is set.
// - Interrupt pin driven low while summary is 1, released otherwise.
// - Load failure flag set on serial memory read failure; sticks until reset.
// - Active-low check flag reads 0 after CRC failure, else 1.
// - CRC failure locks the serial register port until reset.
// - Load complete flag set when memory read cycle ends; sticks until reset.
// - Each calibration field reports its PLL's present six-bit setting.
module gsr_global_status #(
    parameter int NUM_IRQ = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire gsr_pkg::gsr_req_t req,
    output logic [7:0] rdata,
    output logic port_locked,
    input wire logic [gsr_pkg::GPI_WIDTH-1:0] gpio_in,
    input wire logic [gsr_pkg::GPI_WIDTH-1:0] gpio_is_input,
    input wire logic [NUM_IRQ-1:0] irq_status,
    input wire logic [NUM_IRQ-1:0] irq_enable,
    input wire gsr_pkg::gsr_load_evt_t load_evt,
    input wire logic [gsr_pkg::CAL_WIDTH-1:0] cal_code_pll0,
    input wire logic [gsr_pkg::CAL_WIDTH-1:0] cal_code_pll1,
    output logic irq_out_n_o,
    output logic irq_out_n_oe
);
    logic load_failure_flag;
    logic load_complete_flag;
    logic config_check_ok;
    logic irq_summary;
    logic next_load_failure_flag;
    logic next_load_complete_flag;
    logic next_config_check_ok;
    logic next_irq_summary;
    logic [7:0] next_rdata;

    // Load flags are sticky until reset, bus writes are ignored; summary follows enabled status each cycle
    always_comb
    begin
        next_load_failure_flag = load_failure_flag | load_evt.load_fail;
        next_load_complete_flag = load_complete_flag | load_evt.load_done;
        next_config_check_ok = config_check_ok & ~load_evt.crc_error;
        next_irq_summary = |(irq_status & irq_enable);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            load_failure_flag <= gsr_pkg::RESET_FLAG;
            load_complete_flag <= gsr_pkg::RESET_FLAG;
            config_check_ok <= gsr_pkg::RESET_CHECK_OK;
            irq_summary <= gsr_pkg::RESET_FLAG;
        end
        else
        begin
            load_failure_flag <= next_load_failure_flag;
            load_complete_flag <= next_load_complete_flag;
            config_check_ok <= next_config_check_ok;
            irq_summary <= next_irq_summary;
        end
    end

    // Port lock follows the failed check until reset
    assign port_locked = ~config_check_ok;

    // Open-drain interrupt pin: output low, enable low means driving
    assign irq_out_n_o = 1'b0;
    assign irq_out_n_oe = ~irq_summary;

    // Read mux; writes have no path into any field
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (req.addr)
            gsr_pkg::ADDR_INPUT_PIN_LEVELS:
                next_rdata[gsr_pkg::GPI_WIDTH-1:0] = gpio_in & gpio_is_input;
            gsr_pkg::ADDR_INTERRUPT_SUMMARY:
                next_rdata[gsr_pkg::IRQ_BIT] = irq_summary;
            gsr_pkg::ADDR_PLL0_CAL_CODE:
                next_rdata[gsr_pkg::CAL_WIDTH-1:0] = cal_code_pll0;
            gsr_pkg::ADDR_PLL1_CAL_CODE:
                next_rdata[gsr_pkg::CAL_WIDTH-1:0] = cal_code_pll1;
            gsr_pkg::ADDR_BOOT_FAILURE:
                next_rdata[gsr_pkg::FAIL_BIT] = load_failure_flag;
            gsr_pkg::ADDR_CONFIG_LOAD:
            begin
                next_rdata[gsr_pkg::DONE_BIT] = load_complete_flag;
                next_rdata[gsr_pkg::CHECK_OK_BIT] = config_check_ok;
            end
            default:
                next_rdata = 8'h00;
        endcase
        if (!req.rd || port_locked)
            next_rdata = 8'h00;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            rdata <= 8'h00;
        else
            rdata <= next_rdata;
    end

    logic wr_seen;
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            wr_seen <= 1'b0;
        else
            wr_seen <= req.wr;
    end

    a_fail_sticky: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_failure_flag |=> load_failure_flag)
        else $error("load failure flag cleared without reset");

    a_fail_set: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_evt.load_fail |=> load_failure_flag)
        else $error("load failure flag not set");

    a_fail_quiet: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !load_failure_flag && !load_evt.load_fail |=> !load_failure_flag)
        else $error("load failure flag set with no event");

    a_fail_stays: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_failure_flag |=> load_failure_flag [*8])
        else $error("load failure flag not held for eight cycles");

    a_done_sticky: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_evt.load_done |=> load_complete_flag [*2])
        else $error("load complete flag not held");

    a_done_set: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_evt.load_done |=> load_complete_flag)
        else $error("load complete flag not set");

    a_done_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_complete_flag |=> load_complete_flag)
        else $error("load complete flag cleared without reset");

    a_done_quiet: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !load_complete_flag && !load_evt.load_done |=> !load_complete_flag)
        else $error("load complete flag set with no event");

    a_done_stays: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_complete_flag |=> load_complete_flag [*8])
        else $error("load complete flag not held for eight cycles");

    a_crc_low: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_evt.crc_error |=> !config_check_ok && port_locked)
        else $error("check flag or lock wrong after crc error");

    a_check_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !config_check_ok |=> !config_check_ok)
        else $error("check flag returned high without reset");

    a_check_high: assert property (
        @(posedge core_clk) disable iff (!rstn)
        config_check_ok && !load_evt.crc_error |=> config_check_ok)
        else $error("check flag dropped with no crc error");

    a_check_stays: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !config_check_ok |=> !config_check_ok [*8])
        else $error("check flag not held low for eight cycles");

    a_lock_reads: assert property (
        @(posedge core_clk) disable iff (!rstn)
        port_locked |=> rdata == 8'h00)
        else $error("locked port returned data");

    a_lock_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        port_locked |=> port_locked)
        else $error("port lock released without reset");

    a_lock_stays: assert property (
        @(posedge core_clk) disable iff (!rstn)
        port_locked |=> port_locked [*8])
        else $error("port lock not held for eight cycles");

    a_lock_quiet: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !port_locked && !load_evt.crc_error |=> !port_locked)
        else $error("port locked with no crc error");

    a_fail_no_lock: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_evt.load_fail && !load_evt.crc_error && !port_locked
        |=> !port_locked)
        else $error("load failure alone locked the port");

    a_done_no_lock: assert property (
        @(posedge core_clk) disable iff (!rstn)
        load_evt.load_done && !load_evt.crc_error && !port_locked
        |=> !port_locked)
        else $error("load completion alone locked the port");

    a_irq_pin: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (|(irq_status & irq_enable)) |=> !irq_out_n_oe)
        else $error("interrupt pin not driven");

    a_irq_drive_low: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !irq_out_n_oe |-> !irq_out_n_o)
        else $error("interrupt pin driven high");

    a_irq_pin_low: assert property (
        @(posedge core_clk) disable iff (!rstn)
        irq_summary |-> !irq_out_n_oe && !irq_out_n_o)
        else $error("interrupt pin not low while summary set");

    a_irq_let_go: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !irq_summary |-> irq_out_n_oe)
        else $error("interrupt pin held with summary clear");

    a_irq_release: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !(|(irq_status & irq_enable)) |=> irq_out_n_oe && !irq_summary)
        else $error("interrupt summary set with no enabled status");

    a_irq_summary_set: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (|(irq_status & irq_enable)) |=> irq_summary)
        else $error("interrupt summary not set");

    a_irq_disabled: assert property (
        @(posedge core_clk) disable iff (!rstn)
        irq_enable == '0 |=> !irq_summary)
        else $error("interrupt summary set with all sources disabled");

    a_irq_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && !port_locked && req.addr == gsr_pkg::ADDR_INTERRUPT_SUMMARY
        |=> rdata == {7'h00, $past(irq_summary)})
        else $error("interrupt summary read mismatch");

    a_gpi_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && !port_locked && req.addr == gsr_pkg::ADDR_INPUT_PIN_LEVELS
        |=> rdata == {4'h0, $past(gpio_in & gpio_is_input)})
        else $error("pin level read mismatch");

    a_gpi_masked: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && req.addr == gsr_pkg::ADDR_INPUT_PIN_LEVELS
        && gpio_is_input == '0 |=> rdata == 8'h00)
        else $error("pin level shown for pin not configured as input");

    a_cal_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && !port_locked && req.addr == gsr_pkg::ADDR_PLL1_CAL_CODE
        |=> rdata == {2'h0, $past(cal_code_pll1)})
        else $error("calibration read mismatch");

    a_cal0_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && !port_locked && req.addr == gsr_pkg::ADDR_PLL0_CAL_CODE
        |=> rdata == {2'h0, $past(cal_code_pll0)})
        else $error("first calibration read mismatch");

    a_fail_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && !port_locked && req.addr == gsr_pkg::ADDR_BOOT_FAILURE
        |=> rdata == {7'h00, $past(load_failure_flag)})
        else $error("load failure read mismatch");

    a_load_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && !port_locked && req.addr == gsr_pkg::ADDR_CONFIG_LOAD
        |=> rdata == {4'h0, $past(config_check_ok), 2'h0,
        $past(load_complete_flag)})
        else $error("load status read mismatch");

    a_rsvd_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && req.addr == gsr_pkg::ADDR_RESERVED_STATUS
        |=> rdata == 8'h00)
        else $error("reserved register read not zero");

    a_unmapped_read: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.rd && (req.addr < gsr_pkg::ADDR_INPUT_PIN_LEVELS
        || req.addr > gsr_pkg::ADDR_CONFIG_LOAD) |=> rdata == 8'h00)
        else $error("unmapped address read not zero");

    a_write_quiet: assert property (
        @(posedge core_clk) disable iff (!rstn)
        req.wr && !req.rd |=> rdata == 8'h00)
        else $error("write cycle returned read data");

    a_write_inert: assert property (
        @(posedge core_clk) disable iff (!rstn)
        wr_seen && !$past(load_evt.load_fail) |-> $stable(load_failure_flag))
        else $error("write changed status flag");

    a_write_done: assert property (
        @(posedge core_clk) disable iff (!rstn)
        wr_seen && !$past(load_evt.load_done)
        |-> $stable(load_complete_flag))
        else $error("write changed load complete flag");

    a_write_check: assert property (
        @(posedge core_clk) disable iff (!rstn)
        wr_seen && !$past(load_evt.crc_error) |-> $stable(config_check_ok))
        else $error("write changed check flag");
endmodule : gsr_global_status

/* dv/gsr_host_model.sv */
// Host model: register requests and the pulled-up interrupt wire
module gsr_host_model (
    input wire logic core_clk,
    output gsr_pkg::gsr_req_t req,
    input wire logic irq_out_n_o,
    input wire logic irq_out_n_oe,
    output logic irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up holds the wire high when released
    assign irq_pin = irq_out_n_oe ? 1'h1 : irq_out_n_o;
    initial req = '0;
    task automatic xfer(input logic [15:0] a, input logic w,
                        input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, rd: ~w, wr: w, wdata: d};
        @(posedge core_clk);
        req <= '0;
    endtask : xfer
endmodule : gsr_host_model

/* dv/global_status_registers_tb_top.sv */
// Testbench for the global status register bank
module global_status_registers_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic [3:0] gpio_in = 4'h0;
    logic [3:0] gpio_is_input = 4'h0;
    logic [7:0] irq_status = 8'h00;
    logic [7:0] irq_enable = 8'h00;
    gsr_pkg::gsr_load_evt_t load_evt = '0;
    logic [5:0] cal_code_pll0 = 6'h00;
    logic [5:0] cal_code_pll1 = 6'h00;
    gsr_pkg::gsr_req_t req;
    logic [7:0] rdata;
    logic port_locked, irq_out_n_o, irq_out_n_oe, irq_pin;
    int bad_count = 0;
    int n_tests = 0;
    gsr_global_status u_gsr_global_status (.core_clk, .rstn, .req, .rdata,
        .port_locked, .gpio_in, .gpio_is_input, .irq_status, .irq_enable,
        .load_evt, .cal_code_pll0, .cal_code_pll1, .irq_out_n_o,
        .irq_out_n_oe);
    gsr_host_model u_gsr_host_model (.core_clk, .req, .irq_out_n_o,
        .irq_out_n_oe, .irq_pin);
    initial forever #12.5 core_clk = ~core_clk;
    function automatic logic [7:0] exp_irq();
        return {7'h00, |(irq_status & irq_enable)};
    endfunction : exp_irq
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        u_gsr_host_model.xfer(a, 1'h0, 8'h00);
        #1 chk($sformatf("read %h", a), exp, rdata);
    endtask : rd
    task automatic pulse(input logic [2:0] e);
        @(posedge core_clk);
        load_evt <= e;
        @(posedge core_clk);
        load_evt <= '0;
        #1;
    endtask : pulse
    task automatic end_of_test();
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        void'($urandom(32'hfb87));
        repeat (10) @(posedge core_clk);
        rstn <= 1'h1;
        rd(gsr_pkg::ADDR_CONFIG_LOAD, 8'h08);
        rd(gsr_pkg::ADDR_RESERVED_STATUS, 8'h00);
        rd(16'h0300, 8'h00);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge core_clk);
            {gpio_in, gpio_is_input, cal_code_pll0, cal_code_pll1} <=
                20'($urandom);
            irq_status <= 8'($urandom);
            irq_enable <= (i % 4 == 0) ? 8'h00 : 8'($urandom);
            @(posedge core_clk);
            #1 chk("irq pin", ~exp_irq() & 8'h01, {7'h00, irq_pin});
            u_gsr_host_model.xfer(gsr_pkg::ADDR_PLL0_CAL_CODE, 1'h1,
                8'($urandom) & 8'h3f);
            rd(gsr_pkg::ADDR_INPUT_PIN_LEVELS,
                {4'h0, gpio_in & gpio_is_input});
            rd(gsr_pkg::ADDR_INTERRUPT_SUMMARY, exp_irq());
            rd(gsr_pkg::ADDR_PLL0_CAL_CODE, {2'h0, cal_code_pll0});
            rd(gsr_pkg::ADDR_PLL1_CAL_CODE, {2'h0, cal_code_pll1});
        end
        pulse(3'h2);
        rd(gsr_pkg::ADDR_CONFIG_LOAD, 8'h09);
        pulse(3'h4);
        rd(gsr_pkg::ADDR_BOOT_FAILURE, 8'h01);
        rd(gsr_pkg::ADDR_CONFIG_LOAD, 8'h09);
        pulse(3'h1);
        chk("port locked", 8'h01, {7'h00, port_locked});
        rd(gsr_pkg::ADDR_BOOT_FAILURE, 8'h00);
        @(posedge core_clk);
        rstn <= 1'h0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'h1;
        rd(gsr_pkg::ADDR_CONFIG_LOAD, 8'h08);
        rd(gsr_pkg::ADDR_BOOT_FAILURE, 8'h00);
        chk("port locked", 8'h00, {7'h00, port_locked});
        end_of_test();
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        end_of_test();
    end
endmodule : global_status_registers_tb_top
